// file: verilog/rsts_cfg.svh
// Constants of the radio state timing and status block.
// Assumes a 10 MHz system clock; every microsecond count is derived from that rate.
`ifndef RSTS_CFG_SVH
`define RSTS_CFG_SVH

`define RSTS_CLK_MHZ        10
`define RSTS_CYC(us)        ((us) * `RSTS_CLK_MHZ)
`define RSTS_CNT_W          14

// Register offsets and status field layout
`define RSTS_ADDR_STATUS    6'h01
`define RSTS_ADDR_STATE     6'h02
`define RSTS_BIT_DONE       7
`define RSTS_BIT_RESULT     6
`define RSTS_STATUS_RST     8'h00
`define RSTS_CMD_RST        5'h00

// Times in microseconds
`define RSTS_T_WAKE_TYP_US  360
`define RSTS_T_WAKE_MAX_US  1000
`define RSTS_T_SLPW_TYP_US  210
`define RSTS_T_XTAL_TYP_US  330
`define RSTS_T_XTAL_MAX_US  1000
`define RSTS_T_PLL_INIT_US  250
`define RSTS_T_ANALOG_REGULATOR_US     40
`define RSTS_T_PLL_SW_US    100
`define RSTS_T_CF_MIN_US    8
`define RSTS_T_CF_MAX_US    24
`define RSTS_T_DCU_US       6
`define RSTS_T_RXTX_US      16
`define RSTS_T_TXRX_US      32
`define RSTS_T_FAST_US      1
`define RSTS_T_RSSI_US      2
`define RSTS_T_RND_US       1
`define RSTS_T_MEAS_TYP_US  135
`define RSTS_T_MEAS_MAX_US  180

// Output clock: half periods in system cycles, and sleep entry count
`define RSTS_DERIVED_OUTPUT_CLOCK_HALF_FAST 7'h02
`define RSTS_DERIVED_OUTPUT_CLOCK_HALF_SLOW 7'h20
`define RSTS_DERIVED_OUTPUT_CLOCK_SLP_CYC   14'h0023

`endif

// file: verilog/rsts_pkg.sv
// Types of the radio state timing and status block.
// Used by the core and by its cycle timer.
package rsts_pkg;

  typedef enum logic [4:0] {
    CMD_NOP   = 5'h00,
    CMD_TXGO  = 5'h02,
    CMD_FIDLE = 5'h03,
    CMD_FPLL  = 5'h04,
    CMD_RXON  = 5'h06,
    CMD_IDLE  = 5'h08,
    CMD_PLL   = 5'h09,
    CMD_PREP  = 5'h10,
    CMD_AACK  = 5'h16,
    CMD_ARET  = 5'h19
  } rsts_cmd_type;

  typedef enum logic [3:0] {
    ST_P_ON, ST_BUSY_RX, ST_BUSY_TX, ST_RX_ON, ST_IDLE, ST_PLL_ON,
    ST_SLEEP, ST_PREP, ST_DEEP, ST_AA_BUSY, ST_AR_BUSY, ST_AA_LISTEN,
    ST_AR_READY
  } rsts_st_type;

  typedef struct packed {
    logic [13:0] cnt;
    logic        run;
    logic        done;
  } rsts_tmr_type;

  typedef struct packed {
    rsts_st_type state;
    rsts_st_type target;
    logic        pend;
    logic        x_run;
    logic        derived_output_clock_ok;
    logic        use_derived_output_clock;
    logic [4:0]  cmd;
    logic        done;
    logic        result;
    logic        meas_run;
    logic        meas_ed;
    logic        ed_done;
    logic [1:0]  trig_sync;
    logic        trig_prev;
    logic [3:0]  us_cnt;
    logic        rssi_ph;
    logic        rssi_p;
    logic        rnd_p;
    logic [6:0]  derived_output_clock_cnt;
    logic        derived_output_clock;
    logic        derived_output_clock_tick;
    logic [7:0]  rdata;
    logic        ack;
  } rsts_state_type;

endpackage

// file: verilog/rsts_timer.sv
// Down-counting cycle timer: load a count, step it, get a done pulse.
// Assumes load and step come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module rsts_timer (
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_load,
  input  wire logic [13:0] i_count,
  input  wire logic        i_step,
  output logic             o_done,
  output logic             o_busy
);
  import rsts_pkg::*;

  rsts_tmr_type r_reg;
  rsts_tmr_type r_next;

  // Load wins over stepping; a zero count finishes at once
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (i_load) begin
      r_next.cnt = i_count;
      r_next.run = (i_count != 14'h0000);
      r_next.done = (i_count == 14'h0000);
    end else if (r_reg.run && i_step) begin
      if (r_reg.cnt <= 14'h0001) begin
        r_next.cnt  = 14'h0000;
        r_next.run  = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt - 14'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_done = r_reg.done;
  assign o_busy = r_reg.run;

endmodule

`default_nettype wire

// file: verilog/rsts_core.sv
// Radio operating-state controller: state encoding, timed transitions,
// status and command registers, output clock and measurement timing.
// Assumes a register port driven by a host on the same clock and an
// asynchronous trigger pin; analogue blocks are outside.
//
// Contract
// - Lowest power to idle takes 360 us typical, 1000 us worst.
// - Pre-lowpower to lowest power takes 35 output clocks, 0 if slow.
// - Output clock available 330 us typical, 1000 us worst after start.
// - Idle to synth-ready settles in 250 us including regulator time.
// - Channel change resettles the synthesizer within 100 us.
// - Center calibration 8 to 24 us, DC-unit calibration 6 us.
// - Receive to transmit 16 us, transmit to receive 32 us.
// - Signal strength refreshes every 2 us in receive states.
// - Energy detection spans eight symbols, 135 us typical, 180 worst.
// - Channel check takes 135/180 us, then done and result update.
// - A fresh random value every 1 us.
// - Read-only status register at 0x01 shows state and check outcome.
// - Bit 7 done, bit 6 result, bit 5 reserved, 4:0 state; reset 0.
// - Basic state codes as enumerated; other codes reserved.
// - Codes 0x11, 0x12, 0x16, 0x19 only in extended mode.
// - No register answer in sleep or lowest power; host avoids it.
// - Pending transition reads as code 0x1F.
// - Change starts on command write at 0x02 or trigger rising edge; the code also wakes from sleep on a falling edge.
// - Each command write starts a transition toward its state; the code ignores all but forced ones while one is pending.
// - Command field resets to 0x00 and decodes the listed codes.
// - Forced synth-ready ignored in power-on, sleep states or toward them.
`timescale 1ns/1ns
`default_nettype none
`include "rsts_cfg.svh"

module rsts_core #(
  parameter bit P_WORST = 1'b0,
  parameter int P_XTAL_CYC = P_WORST ? `RSTS_CYC(`RSTS_T_XTAL_MAX_US)
                                     : `RSTS_CYC(`RSTS_T_XTAL_TYP_US),
  parameter int P_WAKE_CYC = P_WORST ? `RSTS_CYC(`RSTS_T_WAKE_MAX_US)
                                     : `RSTS_CYC(`RSTS_T_WAKE_TYP_US),
  parameter int P_SLPW_CYC = P_WORST ? `RSTS_CYC(`RSTS_T_WAKE_MAX_US)
                                     : `RSTS_CYC(`RSTS_T_SLPW_TYP_US)
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic [5:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_sleep_transmit_trigger,
  input  wire logic       i_derived_output_clock_slow,
  input  wire logic       i_channel_change,
  input  wire logic       i_cal_start,
  input  wire logic       i_frame_start,
  input  wire logic       i_frame_end,
  input  wire logic       i_tx_end,
  input  wire logic       i_cca_request,
  input  wire logic       i_ed_request,
  input  wire logic       i_channel_clear,
  output logic [7:0]      o_reg_rdata,
  output logic            o_reg_ack,
  output logic            o_derived_output_clock,
  output logic            o_derived_output_clock_available,
  output logic [4:0]      o_state_code,
  output logic            o_rssi_update,
  output logic            o_random_update,
  output logic            o_ed_done
);
  import rsts_pkg::*;

  localparam logic [13:0] C_FAST = 14'(`RSTS_CYC(`RSTS_T_FAST_US));
  localparam logic [13:0] C_INIT = 14'(`RSTS_CYC(`RSTS_T_PLL_INIT_US));
  localparam logic [13:0] C_SW   = 14'(`RSTS_CYC(`RSTS_T_PLL_SW_US));
  localparam logic [13:0] C_CAL  = 14'(`RSTS_CYC((P_WORST ?
    `RSTS_T_CF_MAX_US : `RSTS_T_CF_MIN_US) + `RSTS_T_DCU_US));
  localparam logic [13:0] C_RXTX = 14'(`RSTS_CYC(`RSTS_T_RXTX_US));
  localparam logic [13:0] C_TXRX = 14'(`RSTS_CYC(`RSTS_T_TXRX_US));
  localparam logic [13:0] C_MEAS = 14'(`RSTS_CYC(P_WORST ?
    `RSTS_T_MEAS_MAX_US : `RSTS_T_MEAS_TYP_US));
  localparam logic [3:0]  C_US   = 4'(`RSTS_CYC(`RSTS_T_RND_US) - 1);
  localparam logic [13:0] C_XTAL = 14'(P_XTAL_CYC);
  localparam logic [13:0] C_WAKE = 14'(P_WAKE_CYC);
  localparam logic [13:0] C_SLPW = 14'(P_SLPW_CYC);

  // extended codes only from extended states
  function automatic logic [4:0] code_of(input rsts_st_type s);
    unique case (s)
      ST_P_ON:      code_of = 5'h00;
      ST_BUSY_RX:   code_of = 5'h01;
      ST_BUSY_TX:   code_of = 5'h02;
      ST_RX_ON:     code_of = 5'h06;
      ST_IDLE:      code_of = 5'h08;
      ST_PLL_ON:    code_of = 5'h09;
      ST_SLEEP:     code_of = 5'h0f;
      ST_DEEP:      code_of = 5'h0f;
      ST_PREP:      code_of = 5'h10;
      ST_AA_BUSY:   code_of = 5'h11;
      ST_AR_BUSY:   code_of = 5'h12;
      ST_AA_LISTEN: code_of = 5'h16;
      ST_AR_READY:  code_of = 5'h19;
      default:      code_of = 5'h1f;
    endcase
  endfunction

  // States whose synthesizer is already running
  function automatic logic pll_up(input rsts_st_type s);
    pll_up = (s == ST_PLL_ON) || (s == ST_RX_ON) || (s == ST_AA_LISTEN) ||
             (s == ST_AR_READY);
  endfunction

  // Power-on or sleeping states where forced commands do not apply
  function automatic logic dormant(input rsts_st_type s);
    dormant = (s == ST_P_ON) || (s == ST_SLEEP) || (s == ST_DEEP);
  endfunction

  rsts_state_type r_reg;
  rsts_state_type r_next;

  logic        tmr_load;
  logic [13:0] tmr_count;
  logic        tmr_step;
  logic        tmr_done;
  logic        tmr_busy;
  logic        meas_load;
  logic        meas_done;
  logic        go;
  rsts_st_type go_tgt;
  logic [13:0] go_cnt;
  logic        go_derived_output_clock;

  // transition timer on the device clock
  rsts_timer u_trans (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_load    (tmr_load),
    .i_count   (tmr_count),
    .i_step    (tmr_step),
    .o_done    (tmr_done),
    .o_busy    (tmr_busy)
  );

  // measurement timer shared by energy detection and channel check
  rsts_timer u_meas (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_load    (meas_load),
    .i_count   (C_MEAS),
    .i_step    (1'b1),
    .o_done    (meas_done),
    .o_busy    ()
  );

  // Next-state logic of the whole controller
  always_comb begin
    logic        access;
    logic        rise;
    logic        fall;
    logic        rx_st;
    rsts_st_type s;
    access  = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    rx_st   = 1'b0;
    s       = r_reg.state;
    r_next  = r_reg;
    go      = 1'b0;
    go_tgt  = r_reg.state;
    go_cnt  = C_FAST;
    go_derived_output_clock = 1'b0;
    tmr_load  = 1'b0;
    tmr_count = C_XTAL;
    meas_load = 1'b0;
    r_next.ack       = 1'b0;
    r_next.rnd_p     = 1'b0;
    r_next.rssi_p    = 1'b0;
    r_next.ed_done   = 1'b0;
    r_next.derived_output_clock_tick = 1'b0;

    // Trigger pin: two flops, then edge detect on the second
    r_next.trig_sync = {r_reg.trig_sync[0], i_sleep_transmit_trigger};
    r_next.trig_prev = r_reg.trig_sync[1];
    rise = r_reg.trig_sync[1] && !r_reg.trig_prev;
    fall = !r_reg.trig_sync[1] && r_reg.trig_prev;
    // register port goes deaf in both sleep states
    access = (s != ST_SLEEP) && (s != ST_DEEP);
    rx_st = (s == ST_RX_ON) || (s == ST_BUSY_RX) ||
            (s == ST_AA_LISTEN) || (s == ST_AA_BUSY);

    // oscillator start after reset, then output clock available
    if (s == ST_P_ON && !r_reg.derived_output_clock_ok && !r_reg.x_run) begin
      r_next.x_run = 1'b1;
      tmr_load     = 1'b1;
    end

    // Register access, answered one cycle later
    if (access && (i_reg_rd || i_reg_wr)) begin
      r_next.ack = 1'b1;
      unique case (i_reg_addr)
        // status read shows state and check outcome
        // done, result, reserved zero, state field
        `RSTS_ADDR_STATUS: r_next.rdata = {r_reg.done, r_reg.result,
          1'b0, r_reg.pend ? 5'h1f : code_of(s)};
        `RSTS_ADDR_STATE:  r_next.rdata = {3'h0, r_reg.cmd};
        default:           r_next.rdata = 8'h00;
      endcase
    end

    // toward the state named by the code
    if (access && i_reg_wr && i_reg_addr == `RSTS_ADDR_STATE) begin
      r_next.cmd = i_reg_wdata[4:0];
      unique case (i_reg_wdata[4:0])
        CMD_FIDLE: if (!dormant(s)) begin
          go = 1'b1; go_tgt = ST_IDLE;
        end
        CMD_FPLL: if (!dormant(s) && !(r_reg.pend &&
                      dormant(r_reg.target))) begin
          go = 1'b1; go_tgt = ST_PLL_ON;
          go_cnt = (s == ST_IDLE) ? C_INIT : C_FAST;
        end
        default: if (!r_reg.pend) begin
          unique case (i_reg_wdata[4:0])
            // wake to idle from power-on uses the long wake time
            CMD_IDLE: if (s == ST_P_ON ? r_reg.derived_output_clock_ok : 1'b1) begin
              go = 1'b1; go_tgt = ST_IDLE;
              go_cnt = (s == ST_P_ON) ? C_WAKE : C_FAST;
            end
            CMD_PLL, CMD_RXON, CMD_AACK, CMD_ARET:
              if (s == ST_IDLE || pll_up(s) || s == ST_BUSY_RX) begin
                go = 1'b1;
                go_cnt = (s == ST_IDLE) ? C_INIT : C_FAST;
                go_tgt = (i_reg_wdata[4:0] == CMD_PLL) ? ST_PLL_ON :
                         (i_reg_wdata[4:0] == CMD_RXON) ? ST_RX_ON :
                         (i_reg_wdata[4:0] == CMD_AACK) ? ST_AA_LISTEN :
                         ST_AR_READY;
              end
            CMD_PREP: if (s == ST_IDLE) begin
              go = 1'b1; go_tgt = ST_PREP;
            end
            // transmit start settles receive to transmit
            CMD_TXGO: if (s == ST_PLL_ON || s == ST_AR_READY) begin
              go = 1'b1; go_cnt = C_RXTX;
              go_tgt = (s == ST_PLL_ON) ? ST_BUSY_TX : ST_AR_BUSY;
            end
            default: ;
          endcase
        end
      endcase
    end else if (!r_reg.pend) begin
      // trigger pin edges in the states that accept them
      // lowest power entry counts output clocks
      if (rise && (s == ST_IDLE || s == ST_PREP)) begin
        go = 1'b1; go_derived_output_clock = 1'b1;
        go_tgt = (s == ST_IDLE) ? ST_SLEEP : ST_DEEP;
        go_cnt = i_derived_output_clock_slow ? 14'h0000 : `RSTS_DERIVED_OUTPUT_CLOCK_SLP_CYC;
      end else if (rise && (s == ST_PLL_ON || s == ST_AR_READY)) begin
        go = 1'b1; go_cnt = C_RXTX;
        go_tgt = (s == ST_PLL_ON) ? ST_BUSY_TX : ST_AR_BUSY;
      end else if (fall && (s == ST_SLEEP || s == ST_DEEP)) begin
        go = 1'b1; go_tgt = ST_IDLE;
        go_cnt = (s == ST_DEEP) ? C_WAKE : C_SLPW;
      end else if (i_tx_end && (s == ST_BUSY_TX || s == ST_AR_BUSY)) begin
        go = 1'b1; go_cnt = C_TXRX;
        go_tgt = (s == ST_BUSY_TX) ? ST_PLL_ON : ST_AR_READY;
      end else if (i_channel_change && pll_up(s)) begin
        go = 1'b1; go_cnt = C_SW;
      end else if (i_cal_start && pll_up(s)) begin
        go = 1'b1; go_cnt = C_CAL;
      end else if (i_frame_start && s == ST_RX_ON) begin
        r_next.state = ST_BUSY_RX;
      end else if (i_frame_start && s == ST_AA_LISTEN) begin
        r_next.state = ST_AA_BUSY;
      end else if (i_frame_end && s == ST_BUSY_RX) begin
        r_next.state = ST_RX_ON;
      end else if (i_frame_end && s == ST_AA_BUSY) begin
        r_next.state = ST_AA_LISTEN;
      end
    end

    if (go) begin
      r_next.pend     = 1'b1;
      r_next.target   = go_tgt;
      r_next.use_derived_output_clock = go_derived_output_clock;
      tmr_load        = 1'b1;
      tmr_count       = go_cnt;
    end else if (tmr_done && r_reg.x_run) begin
      r_next.x_run   = 1'b0;
      r_next.derived_output_clock_ok = 1'b1;
    end else if (tmr_done && r_reg.pend) begin
      // pending code to target in one step
      r_next.pend    = 1'b0;
      r_next.state   = r_reg.target;
      r_next.derived_output_clock_ok = !(r_reg.target == ST_SLEEP ||
                         r_reg.target == ST_DEEP);
    end

    // Output clock divider, stopped until available and in sleep
    if (r_reg.derived_output_clock_ok) begin
      if (r_reg.derived_output_clock_cnt == 7'h00) begin
        r_next.derived_output_clock_cnt = (i_derived_output_clock_slow ? `RSTS_DERIVED_OUTPUT_CLOCK_HALF_SLOW
                                       : `RSTS_DERIVED_OUTPUT_CLOCK_HALF_FAST) - 7'h01;
        r_next.derived_output_clock      = !r_reg.derived_output_clock;
        r_next.derived_output_clock_tick = !r_reg.derived_output_clock;
      end else begin
        r_next.derived_output_clock_cnt = r_reg.derived_output_clock_cnt - 7'h01;
      end
    end else begin
      r_next.derived_output_clock_cnt = 7'h00;
      r_next.derived_output_clock     = 1'b0;
    end

    // microsecond tick gives the random refresh
    // every second tick refreshes signal strength
    if (r_reg.us_cnt == C_US) begin
      r_next.us_cnt  = 4'h0;
      r_next.rnd_p   = 1'b1;
      r_next.rssi_ph = !r_reg.rssi_ph;
      r_next.rssi_p  = rx_st && r_reg.rssi_ph;
    end else begin
      r_next.us_cnt = r_reg.us_cnt + 4'h1;
    end

    // energy detection and channel check measurement
    if (!r_reg.meas_run && rx_st && (i_cca_request || i_ed_request)) begin
      meas_load       = 1'b1;
      r_next.meas_run = 1'b1;
      r_next.meas_ed  = !i_cca_request;
      if (i_cca_request) begin
        r_next.done = 1'b0;
      end
    end else if (meas_done) begin
      // a channel check updates done and result at the end
      r_next.meas_run = 1'b0;
      r_next.ed_done  = r_reg.meas_ed;
      if (!r_reg.meas_ed) begin
        r_next.done   = 1'b1;
        r_next.result = i_channel_clear;
      end
    end
  end

  // Step on output clock rising edges only when counting output clocks
  assign tmr_step = r_reg.use_derived_output_clock ? r_reg.derived_output_clock_tick : 1'b1;

  // all state, status bits included, resets to zero
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg       <= '0;
      r_reg.state <= ST_P_ON;
      r_reg.target <= ST_P_ON;
      r_reg.cmd   <= `RSTS_CMD_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs from the state register; the state code is decoded from it
  assign o_reg_rdata            = r_reg.rdata;
  assign o_reg_ack              = r_reg.ack;
  assign o_derived_output_clock = r_reg.derived_output_clock;
  assign o_derived_output_clock_available       = r_reg.derived_output_clock_ok;
  assign o_state_code = r_reg.pend ? 5'h1f : code_of(r_reg.state);
  assign o_rssi_update          = r_reg.rssi_p;
  assign o_random_update        = r_reg.rnd_p;
  assign o_ed_done              = r_reg.ed_done;

endmodule

`default_nettype wire

// file: verification/rsts_core_properties.sv
// Checker of the state block: register answers, state codes, pulses.
// Assumes it is bound to the core and sees only the core's ports.
`timescale 1ns/1ns
`default_nettype none

module rsts_core_checker (
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic [5:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_reg_ack,
  input wire logic [4:0] o_state_code,
  input wire logic       o_rssi_update,
  input wire logic       o_random_update
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  // An access only counts while the state code is not the sleep code 0x0f
  logic acc;
  assign acc = (i_reg_rd || i_reg_wr) && o_state_code != 5'h0f;

  chk_ack_given: assert property (acc |=> o_reg_ack)
    else $error("register access not answered");
  chk_ack_refused: assert property (!acc |=> !o_reg_ack)
    else $error("answer without an awake access");
  chk_status_layout: assert property (
    acc && i_reg_rd && i_reg_addr == 6'h01 |=>
      !o_reg_rdata[5] && o_reg_rdata[4:0] == $past(o_state_code))
    else $error("status read does not match the state code");
  chk_unmapped_zero: assert property (
    acc && i_reg_rd && i_reg_addr > 6'h02 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_pend_code: assert property (
    i_reg_wr && i_reg_addr == 6'h02 && i_reg_wdata[4:0] == 5'h09 &&
      o_state_code == 5'h08 |=> o_state_code == 5'h1f ##1
      o_state_code == 5'h1f)
    else $error("pending code missing after command");
  chk_settle_code: assert property (
    $past(o_state_code) == 5'h1f && o_state_code != 5'h1f |->
      o_state_code inside {5'h00, 5'h01, 5'h02, 5'h06, 5'h08, 5'h09,
                           5'h0f, 5'h10, 5'h11, 5'h12, 5'h16, 5'h19})
    else $error("pending code left toward a reserved code");
  chk_code_legal: assert property (
    o_state_code inside {5'h00, 5'h01, 5'h02, 5'h06, 5'h08, 5'h09, 5'h0f,
                         5'h10, 5'h11, 5'h12, 5'h16, 5'h19, 5'h1f})
    else $error("reserved state code shown");
  chk_random_period: assert property (
    o_random_update |=> !o_random_update[*8] ##1 !o_random_update ##1
      o_random_update)
    else $error("random update period wrong");
  chk_rssi_spacing: assert property (
    o_rssi_update |=> !o_rssi_update[*8] ##1 !o_rssi_update[*8])
    else $error("signal strength updates too close");
endmodule

bind rsts_core rsts_core_checker u_chk (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack),
  .o_state_code(o_state_code), .o_rssi_update(o_rssi_update),
  .o_random_update(o_random_update)
);

`default_nettype wire

// file: verification/rsts_host.sv
// Host model on the register port: one-cycle strobes, answer sampled.
// Assumes the core answers on the accepting edge and holds it one cycle.
`timescale 1ns/1ns
`default_nettype none

module rsts_host (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_ack,
  output var  logic [5:0] o_reg_addr,
  output var  logic       o_reg_wr,
  output var  logic       o_reg_rd,
  output var  logic [7:0] o_reg_wdata
);
  initial begin
    o_reg_addr = 6'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // one access; no answer in sleep is reported, not waited on
  task automatic access(input logic w, input logic [5:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic ok);
    @(negedge i_sys_clk);
    o_reg_wr = w;
    o_reg_rd = !w;
    o_reg_addr = a;
    o_reg_wdata = d;
    // Answer stands a full cycle after the accepting edge; take it settled
    @(negedge i_sys_clk);
    ok = i_reg_ack;
    q = i_reg_rdata;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
  endtask
endmodule

`default_nettype wire

// file: verification/tb_top.sv
// Testbench of the state block: register reads, timed transitions.
// Assumes shortened wake counts of 50 cycles and a 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic       clk, nrst, trig, slow, cca, ed, clear, ack, avail;
  logic       rssi, rnd, edd, rd, wr, ok;
  logic       chg, cal, fs, fe, txe, derived_output_clock;
  logic [7:0] rdata, wdata, q;
  logic [5:0] addr;
  logic [4:0] code;
  int         n_fail, compares, cyc, n;

  rsts_core #(.P_XTAL_CYC(50), .P_WAKE_CYC(50), .P_SLPW_CYC(50)) uut (
    .i_sys_clk(clk), .i_nrst(nrst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .i_sleep_transmit_trigger(trig),
    .i_derived_output_clock_slow(slow), .i_channel_change(chg), .i_cal_start(cal),
    .i_frame_start(fs), .i_frame_end(fe), .i_tx_end(txe),
    .i_cca_request(cca), .i_ed_request(ed), .i_channel_clear(clear),
    .o_reg_rdata(rdata), .o_reg_ack(ack), .o_derived_output_clock(derived_output_clock),
    .o_derived_output_clock_available(avail), .o_state_code(code), .o_rssi_update(rssi),
    .o_random_update(rnd), .o_ed_done(edd));

  rsts_host u_host (.i_sys_clk(clk), .i_reg_rdata(rdata), .i_reg_ack(ack),
    .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata));

  initial begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end

  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Checks that the last measured count n lies in a window
  task automatic rng(input int lo, input int hi);
    cmp({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask

  task automatic rdr(input logic [5:0] a);
    u_host.access(1'b0, a, 8'h00, q, ok);
  endtask

  task automatic cmd(input logic [4:0] c);
    u_host.access(1'b1, 6'h02, {3'h0, c}, q, ok);
  endtask

  // bounded wait for a settled code; host sends nothing meanwhile
  task automatic wait_code(input logic [4:0] c, input int lim);
    n = 0;
    while (code !== c && n < lim) begin
      @(negedge clk);
      n++;
    end
    cmp({3'h0, code}, {3'h0, c});
  endtask

  // Cycles between two pulses of the random or strength update
  task automatic gap(input bit sel);
    while ((sel ? rnd : rssi) !== 1'b1) @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((sel ? rnd : rssi) !== 1'b1 && n < 100);
  endtask

  task automatic t_reset();
    rdr(6'h01);
    cmp(q, 8'h00);
    rdr(6'h02);
    cmp(q, 8'h00);
    rdr(6'h3f);
    cmp({7'h00, ok}, 8'h01);
    cmp(q, 8'h00);
  endtask

  task automatic t_boot();
    n = 0;
    while (avail !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    cmp({7'h00, avail}, 8'h01);
    // Fast output clock: two cycles high, two low
    @(posedge derived_output_clock);
    @(negedge clk) cmp({7'h00, derived_output_clock}, 8'h01);
    repeat (2) @(negedge clk);
    cmp({7'h00, derived_output_clock}, 8'h00);
    repeat (2) @(negedge clk);
    cmp({7'h00, derived_output_clock}, 8'h01);
    cmd(5'h08);
    rdr(6'h01);
    cmp(q, 8'h1f);
    wait_code(5'h08, 200);
  endtask

  task automatic t_synth();
    cmd(5'h09);
    wait_code(5'h09, 3000);
    rng(2490, 2510);
    rdr(6'h02);
    cmp(q, 8'h09);
  endtask

  task automatic t_rx();
    cmd(5'h06);
    wait_code(5'h06, 40);
    gap(1'b0);
    cmp(n[7:0], 8'h14);
    gap(1'b1);
    cmp(n[7:0], 8'h0a);
  endtask

  task automatic t_meas();
    @(negedge clk) cca = 1'b1;
    @(negedge clk) cca = 1'b0;
    rdr(6'h01);
    cmp(q, 8'h06);
    repeat (1400) @(negedge clk);
    rdr(6'h01);
    cmp(q, 8'hc6);
    @(negedge clk) ed = 1'b1;
    @(negedge clk) ed = 1'b0;
    n = 1;
    while (edd !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    rng(1345, 1360);
  endtask

  // Retune, calibration and frame from receive listen, transmit turnaround from synth-ready
  task automatic t_link();
    @(negedge clk) chg = 1'b1;
    @(negedge clk) chg = 1'b0;
    wait_code(5'h06, 1100);
    rng(995, 1005);
    @(negedge clk) cal = 1'b1;
    @(negedge clk) cal = 1'b0;
    wait_code(5'h06, 400);
    rng(139, 141);
    @(negedge clk) fs = 1'b1;
    @(negedge clk) fs = 1'b0;
    cmp({3'h0, code}, 8'h01);
    @(negedge clk) fe = 1'b1;
    @(negedge clk) fe = 1'b0;
    cmp({3'h0, code}, 8'h06);
    cmd(5'h09);
    wait_code(5'h09, 40);
    cmd(5'h02);
    wait_code(5'h02, 400);
    rng(158, 163);
    @(negedge clk) txe = 1'b1;
    @(negedge clk) txe = 1'b0;
    wait_code(5'h09, 400);
    rng(318, 322);
  endtask

  task automatic t_sleep();
    cmd(5'h03);
    wait_code(5'h08, 40);
    // Slow output clock: sleep entry needs no output clock cycles
    @(negedge clk) {slow, trig} = 2'b11;
    wait_code(5'h0f, 400);
    rng(3, 5);
    rdr(6'h01);
    cmp({7'h00, ok}, 8'h00);
    cmp({7'h00, derived_output_clock}, 8'h00);
    @(negedge clk) {slow, trig} = 2'b00;
    wait_code(5'h08, 300);
  endtask

  task automatic t_prep();
    cmd(5'h10);
    wait_code(5'h10, 40);
    @(negedge clk) trig = 1'b1;
    n = 0;
    wait_code(5'h0f, 400);
    rng(138, 152);
    @(negedge clk) trig = 1'b0;
    wait_code(5'h08, 300);
  endtask

  // Watchdog: the whole run needs well under twenty thousand cycles
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 20000) begin
        n_fail++;
        final_report();
      end
    end
  end

  initial begin
    {nrst, trig, slow, cca, ed, clear} = 6'h00;
    {chg, cal, fs, fe, txe} = 5'h00;
    n_fail = 0;
    compares = 0;
    clear = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    t_reset();
    t_boot();
    t_synth();
    t_rx();
    t_meas();
    t_link();
    t_sleep();
    t_prep();
    final_report();
  end
endmodule

`default_nettype wire
